// [pfs_pkg.sv]
/*
 pfs_pkg: constants and command codes for the program fetch sequencer.
 Assumes: used by pfs_program_fetch_sequencer and pfs_sva; no imports anywhere.
*/
`default_nettype none

package pfs_pkg;

	// ==========================================================
	// widths and stack depth
	localparam int ADDR_W       = 16;
	localparam int WORD_W       = 16;
	localparam int RPT_W        = 8;
	localparam int STACK_DEPTH  = 8;

	// ==========================================================
	// reset values
	localparam logic [15:0] RESET_ADDR  = 16'h0000;
	localparam logic [15:0] RESET_WORD  = 16'h0000;
	localparam logic [7:0]  RESET_RPT   = 8'h00;

	// ==========================================================
	// stack push source select
	localparam logic [1:0] PUSH_PC   = 2'h0;
	localparam logic [1:0] PUSH_ACCUM_LOW_HALF = 2'h1;
	localparam logic [1:0] PUSH_DATA = 2'h2;

	// ==========================================================
	// sequencer states
	typedef enum logic [2:0] {
		ST_RUN    = 3'b001,
		ST_BORROW = 3'b010,
		ST_RESUME = 3'b100
	} pfs_state_e;

endpackage : pfs_pkg

`default_nettype wire

// [pfs_prog_mem.sv]
/*
 pfs_prog_mem: program memory model, word = address xor 16'h5a3c.
 Assumes: sequencer shows progAddrBus with progRead; no wait states.
*/
`default_nettype none
module pfs_prog_mem (
	input wire logic		clock,
	input wire logic [15:0]	progAddrBus,
	input wire logic		progRead,
	input wire logic		borrowActive,
	input wire logic [15:0]	prefetchAddrCounter,
	output logic [15:0]		progData
);
	// ==========================================================
	localparam logic [15:0] SCRAMBLE = 16'h5a3c;
	// zero-wait answer inside the read cycle; the sequencer takes it at
	// the edge closing that cycle. outside a read and outside a borrow the
	// inverse shows, so a sample taken a cycle late never matches
	assign progData = borrowActive ? (prefetchAddrCounter ^ SCRAMBLE)
		: progRead ? (progAddrBus ^ SCRAMBLE) : ~(progAddrBus ^ SCRAMBLE);
endmodule : pfs_prog_mem
`default_nettype wire

// [pfs_program_fetch_sequencer.sv]
/*
 pfs_program_fetch_sequencer: program sequencing front end of a 16-bit
 signal processor core: prefetch counter with one-word save slot, program
 counter, fetch queue, instruction register, hardware stack, repeat count
 and the program address bus.
 Assumes: all control inputs come from the core decoder on the same clock;
 program memory answers progData within the cycle progAddrBus is shown;
 a fetched word is taken at the edge that ends the read cycle, a mac operand at the edge before progRead.
*/
`default_nettype none

module pfs_program_fetch_sequencer #(
	parameter int  STACK_DEPTH  = pfs_pkg::STACK_DEPTH,
	parameter bit  HAS_PREFETCH = 1'b1
) (
	// clock and reset
	input  wire logic                        clock,
	input  wire logic                        resetn,
	// program memory
	output var  logic [pfs_pkg::ADDR_W-1:0]  progAddrBus,
	output var  logic                        progRead,
	input  wire logic [pfs_pkg::WORD_W-1:0]  progData,
	// fetch and decode control
	input  wire logic                        fetchReq,
	input  wire logic                        decodeStep,
	input  wire logic                        branchTake,
	input  wire logic [pfs_pkg::ADDR_W-1:0]  branchAddr,
	// borrowed addressing (block move, mac, table ops)
	input  wire logic                        borrowStart,
	input  wire logic [pfs_pkg::ADDR_W-1:0]  borrowAddr,
	input  wire logic                        borrowStep,
	input  wire logic                        borrowDone,
	input  wire logic [pfs_pkg::ADDR_W-1:0]  normalDataAddr,
	output var  logic [pfs_pkg::ADDR_W-1:0]  dataAddr,
	output var  logic                        borrowActive,
	output var  logic [pfs_pkg::WORD_W-1:0]  macOperand,
	output var  logic                        macOperandValid,
	// stack
	input  wire logic                        stackPush,
	input  wire logic [1:0]                  stackPushSel,
	input  wire logic                        stackPop,
	input  wire logic                        retTake,
	input  wire logic [pfs_pkg::WORD_W-1:0]  accumLowHalf,
	input  wire logic [pfs_pkg::WORD_W-1:0]  dataIn,
	output var  logic [pfs_pkg::WORD_W-1:0]  stackTop,
	// repeat
	input  wire logic                        repeatLoad,
	input  wire logic [pfs_pkg::RPT_W-1:0]   repeatValue,
	output var  logic [pfs_pkg::RPT_W-1:0]   repeatCount,
	output var  logic                        repeatHold,
	// execution
	output var  logic [pfs_pkg::WORD_W-1:0]  execInstrReg,
	output var  logic [pfs_pkg::ADDR_W-1:0]  progCounter,
	output var  logic [pfs_pkg::ADDR_W-1:0]  prefetchAddrCounter
);

	localparam int SP_W = $clog2(STACK_DEPTH + 1);

	// ==========================================================
	// state
	typedef struct packed {
		pfs_pkg::pfs_state_e               state;
		logic [pfs_pkg::ADDR_W-1:0]        prefetch_addr_counter;
		logic [pfs_pkg::ADDR_W-1:0]        saveSlot;
		logic [pfs_pkg::ADDR_W-1:0]        pc;
		logic [pfs_pkg::ADDR_W-1:0]        fetchedAddr;
		logic [pfs_pkg::WORD_W-1:0]        queue;
		logic                              queueValid;
		logic                              fetchPend;
		logic [pfs_pkg::WORD_W-1:0]        instr;
		logic [STACK_DEPTH-1:0][pfs_pkg::WORD_W-1:0] stack;
		logic [SP_W-1:0]                   sp;
		logic [pfs_pkg::RPT_W-1:0]         rpt;
		logic [pfs_pkg::ADDR_W-1:0]        prog_addr_bus;
		logic                              pread;
		logic [pfs_pkg::ADDR_W-1:0]        daddr;
		logic [pfs_pkg::WORD_W-1:0]        macOp;
		logic                              macValid;
	} pfs_state_s;

	pfs_state_s q;
	pfs_state_s d;

	// ==========================================================
	// helpers
	function automatic logic [pfs_pkg::ADDR_W-1:0] incAddr(
		input logic [pfs_pkg::ADDR_W-1:0] a
	);
		incAddr = a + 16'h0001;
	endfunction : incAddr

	logic [pfs_pkg::ADDR_W-1:0] fetchPtr;
	logic [pfs_pkg::WORD_W-1:0] pushWord;
	logic                       borrowing;

	// reduced variant has no separate counter: the pc does the job
	assign fetchPtr  = HAS_PREFETCH ? q.prefetch_addr_counter : q.pc;
	assign borrowing = (q.state == pfs_pkg::ST_BORROW);

	always_comb
	begin
		if (stackPushSel == pfs_pkg::PUSH_ACCUM_LOW_HALF)
		begin
			pushWord = accumLowHalf;
		end
		else if (stackPushSel == pfs_pkg::PUSH_DATA)
		begin
			pushWord = dataIn;
		end
		else
		begin
			pushWord = q.pc;
		end
	end

	// ==========================================================
	// next state
	always_comb
	begin
		d          = q;
		d.pread    = 1'b0;
		d.macValid = 1'b0;
		d.fetchPend = 1'b0;

		// returned program word lands in the queue first
		if (q.fetchPend)
		begin
			d.queue      = progData;
			d.queueValid = 1'b1;
		end

		case (q.state)
			pfs_pkg::ST_RUN:
			begin
				d.daddr = normalDataAddr;
				if (borrowStart)
				begin
					d.saveSlot = fetchPtr;
					d.state    = pfs_pkg::ST_BORROW;
					if (HAS_PREFETCH)
						d.prefetch_addr_counter = borrowAddr;
					else
						d.pc  = borrowAddr;
				end
				else if (fetchReq && !q.queueValid)
				begin
					d.prog_addr_bus       = fetchPtr;
					d.pread     = 1'b1;
					d.fetchPend = 1'b1;
					d.fetchedAddr = fetchPtr;
					if (HAS_PREFETCH)
						d.prefetch_addr_counter = incAddr(q.prefetch_addr_counter);
				end
			end
			pfs_pkg::ST_BORROW:
			begin
				d.daddr = fetchPtr;
				// mac operands stream over the program bus
				d.prog_addr_bus   = fetchPtr;
				if (borrowStep)
				begin
					d.pread     = 1'b1;
					d.macOp     = progData;
					d.macValid  = 1'b1;
					if (HAS_PREFETCH)
						d.prefetch_addr_counter = incAddr(q.prefetch_addr_counter);
					else
						d.pc  = incAddr(q.pc);
				end
				if (borrowDone)
					d.state = pfs_pkg::ST_RESUME;
			end
			pfs_pkg::ST_RESUME:
			begin
				if (HAS_PREFETCH)
					d.prefetch_addr_counter = q.saveSlot;
				else
					d.pc  = q.saveSlot;
				d.daddr = normalDataAddr;
				d.state = pfs_pkg::ST_RUN;
			end
			default:
			begin
				d.state = pfs_pkg::ST_RUN;
			end
		endcase

		// decode: queue to instruction register once rpt is zero, else rpt counts down; pc moves on now only with HAS_PREFETCH
		if (decodeStep && q.queueValid && !borrowing)
		begin
			if (q.rpt != pfs_pkg::RESET_RPT)
			begin
				d.rpt = q.rpt - 8'h01;
			end
			else
			begin
				d.instr      = q.queue;
				d.queueValid = 1'b0;
				if (HAS_PREFETCH)
					d.pc = incAddr(q.fetchedAddr);
			end
		end

		if (repeatLoad)
			d.rpt = repeatValue;

		// stack; overflow drops the oldest word, underflow keeps last
		if (stackPush)
		begin
			for (int i = STACK_DEPTH - 1; i > 0; i--)
				d.stack[i] = q.stack[i-1];
			d.stack[0] = pushWord;
			if (q.sp != SP_W'(STACK_DEPTH))
				d.sp = q.sp + 1'b1;
		end
		else if (stackPop)
		begin
			for (int i = 0; i < STACK_DEPTH - 1; i++)
				d.stack[i] = q.stack[i+1];
			if (q.sp != '0)
				d.sp = q.sp - 1'b1;
		end

		// branch or return redirects fetch, flushes queued word
		if ((branchTake || retTake) && !borrowing)
		begin
			d.pc = retTake ? q.stack[0] : branchAddr;
			if (HAS_PREFETCH)
				d.prefetch_addr_counter = retTake ? q.stack[0] : branchAddr;
			d.queueValid = 1'b0;
			d.fetchPend  = 1'b0;
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			q       <= '0;
			q.state <= pfs_pkg::ST_RUN;
			q.prefetch_addr_counter   <= pfs_pkg::RESET_ADDR;
			q.pc    <= pfs_pkg::RESET_ADDR;
			q.instr <= pfs_pkg::RESET_WORD;
			q.rpt   <= pfs_pkg::RESET_RPT;
		end
		else
		begin
			q <= d;
		end
	end

	// ==========================================================
	// outputs from flip-flops; borrowActive and repeatHold are decoded from state and rpt
	assign progAddrBus         = q.prog_addr_bus;
	assign progRead            = q.pread;
	assign dataAddr            = q.daddr;
	assign borrowActive        = borrowing;
	assign macOperand          = q.macOp;
	assign macOperandValid     = q.macValid;
	assign stackTop            = q.stack[0];
	assign repeatCount         = q.rpt;
	assign repeatHold          = (q.rpt != pfs_pkg::RESET_RPT);
	assign execInstrReg        = q.instr;
	assign progCounter         = q.pc;
	assign prefetchAddrCounter = fetchPtr;

endmodule : pfs_program_fetch_sequencer

`default_nettype wire

// [pfs_sva.sv]
/*
 pfs_sva: port assertions for the program fetch sequencer.
 Assumes: bound to pfs_program_fetch_sequencer; one clock domain.
*/
`default_nettype none
module pfs_sva (
	input wire logic		clock,
	input wire logic		resetn,
	input wire logic		progRead,
	input wire logic		borrowStart,
	input wire logic [15:0]	borrowAddr,
	input wire logic		borrowStep,
	input wire logic		borrowDone,
	input wire logic		borrowActive,
	input wire logic [15:0]	prefetchAddrCounter,
	input wire logic [15:0]	dataAddr,
	input wire logic [15:0]	progData,
	input wire logic [15:0]	macOperand,
	input wire logic		macOperandValid,
	input wire logic		stackPush,
	input wire logic [1:0]	stackPushSel,
	input wire logic [15:0]	accumLowHalf,
	input wire logic [15:0]	progCounter,
	input wire logic [15:0]	stackTop,
	input wire logic		repeatLoad,
	input wire logic [7:0]	repeatValue,
	input wire logic [7:0]	repeatCount,
	input wire logic		repeatHold
);
	// ==========================================================
	// counter value expected back once the borrow ends
	logic [15:0] savedPfc_q;
	always_ff @(posedge clock or negedge resetn)
		if (!resetn)
			savedPfc_q <= 16'h0;
		else if (borrowStart && !borrowActive)
			savedPfc_q <= prefetchAddrCounter;
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	// resume cycle also shows borrowActive low, so exclude it
	sequence s_take;
		borrowStart && !borrowActive && !$past(borrowActive);
	endsequence
	sequence s_step;
		borrowStep && borrowActive;
	endsequence
	property p_take;
		s_take |=> borrowActive && prefetchAddrCounter == $past(borrowAddr);
	endproperty
	a_take: assert property (p_take) else $error("borrow not taken");
	property p_step;
		s_step |=> progRead
			&& prefetchAddrCounter == $past(prefetchAddrCounter) + 16'h1;
	endproperty
	a_step: assert property (p_step) else $error("step bad");
	property p_mac;
		s_step |=> macOperandValid && macOperand == $past(progData);
	endproperty
	a_mac: assert property (p_mac) else $error("operand bad");
	property p_daddr;
		$past(borrowActive) && borrowActive && $stable(prefetchAddrCounter)
			|-> dataAddr == prefetchAddrCounter;
	endproperty
	a_daddr: assert property (p_daddr) else $error("data addr");
	property p_restore;
		borrowDone && borrowActive
			|-> ##[1:2] !borrowActive && prefetchAddrCounter == savedPfc_q;
	endproperty
	a_restore: assert property (p_restore) else $error("no restore");
	property p_push_pc;
		stackPush && stackPushSel == pfs_pkg::PUSH_PC |=> stackTop == $past(progCounter);
	endproperty
	a_push_pc: assert property (p_push_pc) else $error("push pc");
	property p_push_acc;
		stackPush && stackPushSel == pfs_pkg::PUSH_ACCUM_LOW_HALF |=> stackTop == $past(accumLowHalf);
	endproperty
	a_push_acc: assert property (p_push_acc) else $error("push acc");
	property p_rpt;
		repeatLoad |=> repeatCount == $past(repeatValue) && repeatHold == (repeatCount != 8'h0);
	endproperty
	a_rpt: assert property (p_rpt) else $error("repeat load");
endmodule : pfs_sva
bind pfs_program_fetch_sequencer pfs_sva u_sva (.*);
`default_nettype wire

// [tb_program_fetch_sequencer.sv]
/*
 tb_program_fetch_sequencer: directed scenarios for the sequencer.
 Assumes: pfs_prog_mem as program memory, checker bound separately.
*/
`default_nettype none
module tb_program_fetch_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	logic clock = 1'b0, resetn = 1'b0, fetchReq = 1'b0, decodeStep = 1'b0;
	logic branchTake = 1'b0, borrowStart = 1'b0, borrowStep = 1'b0;
	logic borrowDone = 1'b0, stackPush = 1'b0, stackPop = 1'b0, retTake = 1'b0;
	logic repeatLoad = 1'b0, progRead, borrowActive, macOperandValid, repeatHold;
	logic [1:0] stackPushSel = 2'h0;
	logic [7:0] repeatValue = 8'h00, repeatCount;
	logic [15:0] branchAddr = 16'h0, borrowAddr = 16'h0300, dataIn = 16'h0;
	logic [15:0] normalDataAddr = 16'h0123, accumLowHalf = 16'h0;
	logic [15:0] progData, progAddrBus, dataAddr, macOperand, stackTop;
	logic [15:0] execInstrReg, progCounter, prefetchAddrCounter;
	int err_total = 0, checked = 0;
	always #10 clock = ~clock;
	pfs_program_fetch_sequencer DUT (.*);
	pfs_prog_mem u_mem (.*);
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : cmp
	task automatic report_and_stop();
		$display("checked %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop
	task automatic fetch_decode(input logic [15:0] a);
		@(posedge clock) fetchReq <= 1'b1;
		@(posedge clock) fetchReq <= 1'b0;
		@(negedge clock);
		cmp(progRead, 1'b1);
		cmp(progAddrBus, a);
		cmp(prefetchAddrCounter, a + 16'h1);
		@(posedge clock);
		@(posedge clock) decodeStep <= 1'b1;
		@(negedge clock);
		cmp(progCounter, a);
		@(posedge clock) decodeStep <= 1'b0;
		@(negedge clock);
		cmp(execInstrReg, a ^ 16'h5a3c);
		cmp(progCounter, a + 16'h1);
	endtask : fetch_decode
	task automatic borrow_op();
		@(posedge clock) borrowStart <= 1'b1;
		@(posedge clock) borrowStart <= 1'b0;
		@(negedge clock);
		cmp(prefetchAddrCounter, 16'h0300);
		cmp(borrowActive, 1'b1);
		@(posedge clock) borrowStep <= 1'b1;
		@(posedge clock) borrowStep <= 1'b0;
		@(negedge clock);
		cmp(macOperand, 16'h0300 ^ 16'h5a3c);
		cmp(macOperandValid, 1'b1);
		@(negedge clock);
		cmp(dataAddr, 16'h0301);
		@(posedge clock) borrowDone <= 1'b1;
		@(posedge clock) borrowDone <= 1'b0;
		repeat (2) @(negedge clock);
		cmp(prefetchAddrCounter, 16'h0002);
		cmp(dataAddr, 16'h0123);
		cmp(borrowActive, 1'b0);
	endtask : borrow_op
	task automatic redirect_ops();
		@(posedge clock);
		branchTake <= 1'b1;
		branchAddr <= 16'h0040;
		@(posedge clock) branchTake <= 1'b0;
		@(negedge clock);
		cmp(progCounter, 16'h0040);
		cmp(prefetchAddrCounter, 16'h0040);
		fetch_decode(16'h0040);
		@(posedge clock) retTake <= 1'b1;
		@(posedge clock) retTake <= 1'b0;
		@(negedge clock);
		cmp(progCounter, 16'hbe01);
		cmp(prefetchAddrCounter, 16'hbe01);
	endtask : redirect_ops
	task automatic repeat_decode();
		@(posedge clock);
		fetchReq <= 1'b1;
		repeatLoad <= 1'b1;
		repeatValue <= 8'h02;
		@(posedge clock);
		fetchReq <= 1'b0;
		repeatLoad <= 1'b0;
		@(posedge clock) decodeStep <= 1'b1;
		@(posedge clock);
		@(negedge clock);
		cmp(repeatCount, 16'h0001);
		cmp(execInstrReg, 16'h0040 ^ 16'h5a3c);
		@(posedge clock);
		@(posedge clock) decodeStep <= 1'b0;
		@(negedge clock);
		cmp(execInstrReg, 16'hbe01 ^ 16'h5a3c);
		cmp(progCounter, 16'hbe02);
		cmp(repeatHold, 1'b0);
	endtask : repeat_decode
	task automatic stack_ops();
		logic [15:0] exp [3] = '{16'h0002, 16'hbe01, 16'h1302};
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clock);
			stackPush <= 1'b1;
			stackPushSel <= 2'(i);
			accumLowHalf <= 16'hbe00 + 16'(i);
			dataIn <= 16'h1300 + 16'(i);
			@(posedge clock) stackPush <= 1'b0;
			@(negedge clock);
			cmp(stackTop, exp[i]);
		end
		@(posedge clock) stackPop <= 1'b1;
		@(posedge clock) stackPop <= 1'b0;
		@(negedge clock);
		cmp(stackTop, 16'hbe01);
	endtask : stack_ops
	task automatic repeat_ops();
		for (int i = 0; i < 2; i++)
		begin
			@(posedge clock);
			repeatLoad <= 1'b1;
			repeatValue <= i ? 8'h00 : 8'hff;
			@(posedge clock) repeatLoad <= 1'b0;
			@(negedge clock);
			cmp(repeatCount, i ? 8'h00 : 8'hff);
			cmp(repeatHold, i ? 1'b0 : 1'b1);
		end
	endtask : repeat_ops
	initial
	begin
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		@(negedge clock);
		cmp(progCounter, 16'h0);
		fetch_decode(16'h0000);
		fetch_decode(16'h0001);
		borrow_op();
		stack_ops();
		repeat_ops();
		redirect_ops();
		repeat_decode();
		report_and_stop();
	end
endmodule : tb_program_fetch_sequencer
`default_nettype wire
